//--- hdl/cem_pkg.sv
package cem_pkg;

	// register offsets on the serial register port
	localparam logic [7:0] CEM_OFF_TIMER_MASK = 8'h2A;
	localparam logic [7:0] CEM_OFF_TEMP_MASK  = 8'h2B;
	localparam logic [7:0] CEM_OFF_FAULT_MASK = 8'h2C;

	// reset values
	localparam logic [7:0] CEM_RST_MASK = 8'h00;

	// writable bits of each register; the rest read as zero
	localparam logic [7:0] CEM_WMASK_TIMER = 8'h7F;
	localparam logic [7:0] CEM_WMASK_TEMP  = 8'h1F;
	localparam logic [7:0] CEM_WMASK_FAULT = 8'hFF;
	// temperature-zone bits also cleared on watchdog expiry
	localparam logic [7:0] CEM_TEMP_WD_BITS = 8'h0F;

	// charge/timer register fields
	localparam int CEM_BIT_LINE_DETECT = 6;
	localparam int CEM_BIT_CONV_DONE   = 5;
	localparam int CEM_BIT_MIN_SYS     = 4;
	localparam int CEM_BIT_FAST_TMR    = 3;
	localparam int CEM_BIT_TRICKLE_TMR = 2;
	localparam int CEM_BIT_PRE_TMR     = 1;
	localparam int CEM_BIT_TOPOFF_TMR  = 0;

	// temperature register fields
	localparam int CEM_BIT_COLD = 3;
	localparam int CEM_BIT_COOL = 2;
	localparam int CEM_BIT_WARM = 1;
	localparam int CEM_BIT_HOT  = 0;

	// fault register fields
	localparam int CEM_BIT_BAT_CUR_REG = 7;
	localparam int CEM_BIT_BUS_OVP     = 6;
	localparam int CEM_BIT_BAT_OVP     = 5;
	localparam int CEM_BIT_IN_OCP      = 4;
	localparam int CEM_BIT_BAT_OCP     = 3;
	localparam int CEM_BIT_CONV_OCP    = 2;
	localparam int CEM_BIT_ADP_B_OVP   = 1;
	localparam int CEM_BIT_ADP_A_OVP   = 0;

	// event vector: [6:0] timer/charge, [10:7] temperature, [18:11] fault
	localparam int CEM_NUM_EVENTS = 19;
	localparam int CEM_EV_TEMP_LSB  = 7;
	localparam int CEM_EV_FAULT_LSB = 11;

	// interrupt pulse width in clock cycles
	localparam logic [3:0] CEM_IRQ_PULSE_CYCLES = 4'h1;

endpackage

//--- hdl/cem_mask_if.sv
interface cem_mask_if;
	logic [7:0] timer_mask;
	logic [7:0] temp_mask;
	logic [7:0] fault_mask;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic       reg_rst;
	logic       wd_expire;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	modport regs (
		input  wr_en, wr_addr, wr_data, reg_rst, wd_expire, rd_addr,
		output timer_mask, temp_mask, fault_mask, rd_data
	);
	modport core (
		output wr_en, wr_addr, wr_data, reg_rst, wd_expire, rd_addr,
		input  timer_mask, temp_mask, fault_mask, rd_data
	);
endinterface

//--- hdl/cem_mask_regs.sv
module cem_mask_regs
	import cem_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// register port
	cem_mask_if.regs  mif
);

	typedef struct packed {
		logic [7:0] timer_mask;
		logic [7:0] temp_mask;
		logic [7:0] fault_mask;
		logic [7:0] rd_data;
	} cem_regs_state_t;

	cem_regs_state_t state;
	cem_regs_state_t next_state;

	always_comb begin
		next_state = state;
		if (mif.wr_en) begin
			if (mif.wr_addr == CEM_OFF_TIMER_MASK) begin
				next_state.timer_mask = mif.wr_data & CEM_WMASK_TIMER;
			end else if (mif.wr_addr == CEM_OFF_TEMP_MASK) begin
				next_state.temp_mask = mif.wr_data & CEM_WMASK_TEMP;
			end else if (mif.wr_addr == CEM_OFF_FAULT_MASK) begin
				next_state.fault_mask = mif.wr_data & CEM_WMASK_FAULT;
			end
		end
		// watchdog clears only the zone masks, after any same-cycle write
		if (mif.wd_expire) begin
			next_state.temp_mask = next_state.temp_mask & ~CEM_TEMP_WD_BITS;
		end
		if (mif.reg_rst) begin
			next_state.timer_mask = CEM_RST_MASK;
			next_state.temp_mask  = CEM_RST_MASK;
			next_state.fault_mask = CEM_RST_MASK;
		end
		if (mif.rd_addr == CEM_OFF_TIMER_MASK) begin
			next_state.rd_data = state.timer_mask;
		end else if (mif.rd_addr == CEM_OFF_TEMP_MASK) begin
			next_state.rd_data = state.temp_mask;
		end else if (mif.rd_addr == CEM_OFF_FAULT_MASK) begin
			next_state.rd_data = state.fault_mask;
		end else begin
			next_state.rd_data = 8'h00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign mif.timer_mask = state.timer_mask;
	assign mif.temp_mask  = state.temp_mask;
	assign mif.fault_mask = state.fault_mask;
	assign mif.rd_data    = state.rd_data;

endmodule

//--- hdl/cem_irq_mask.sv
// Notes on behaviour
// - line detect done pulses unless bit 6 set
// - bit 5 gates single-shot conversion done
// - bit 4 gates both min-system transitions
// - bit 3 gates fast-charge timer expiry
// - bit 2 gates trickle timer expiry
// - bit 1 gates pre-charge timer expiry
// - bit 0 gates top-off timer expiry
// - temperature bit 3 gates cold crossing
// - temperature bit 2 gates cool crossing
// - temperature bit 1 gates warm crossing
// - temperature bit 0 gates hot crossing
// - zone masks clear on reset command, watchdog
// - fault bit 7 gates charge-current regulation transitions
// - fault bit 6 gates input bus overvoltage
// - fault bit 5 gates battery overvoltage
// - fault bit 4 gates input overcurrent
// - fault bit 3 gates battery overcurrent
// - fault bit 2 gates converter overcurrent
// - fault bit 1 gates adapter B overvoltage
// - fault bit 0 gates adapter A overvoltage
// - all masks zero at power-up, reset command
module cem_irq_mask
	import cem_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// register port from the serial interface logic
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        reg_rst_cmd_i,
	input  wire logic        watchdog_expire_i,
	// charger event pulses and status levels, same clock domain
	input  wire logic        line_detect_done_i,
	input  wire logic        conv_done_i,
	input  wire logic        conv_single_shot_i,
	input  wire logic        min_sys_reg_i,
	input  wire logic        fast_timer_expire_i,
	input  wire logic        trickle_timer_expire_i,
	input  wire logic        pre_timer_expire_i,
	input  wire logic        topoff_timer_expire_i,
	input  wire logic [3:0]  thermistor_cross_i,
	input  wire logic        bat_cur_reg_i,
	input  wire logic        bus_ovp_i,
	input  wire logic        bat_ovp_i,
	input  wire logic        in_ocp_i,
	input  wire logic        bat_ocp_i,
	input  wire logic        conv_ocp_i,
	input  wire logic        adp_b_ovp_i,
	input  wire logic        adp_a_ovp_i,
	// interrupt to host
	output logic             irq_pulse_o,
	output logic      [18:0] irq_cause_o
);

	cem_mask_if mif ();

	cem_mask_regs u_regs (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.mif     (mif)
	);

	assign mif.wr_en     = reg_wr_i;
	assign mif.wr_addr   = reg_addr_i;
	assign mif.wr_data   = reg_wdata_i;
	assign mif.reg_rst   = reg_rst_cmd_i;
	assign mif.wd_expire = watchdog_expire_i;
	assign mif.rd_addr   = reg_addr_i;
	assign reg_rdata_o   = mif.rd_data;

	typedef struct packed {
		logic        min_sys_q;
		logic        bat_cur_q;
		logic        bus_ovp_q;
		logic        bat_ovp_q;
		logic        adp_b_q;
		logic        adp_a_q;
		logic        irq;
		logic [18:0] cause;
	} cem_core_state_t;

	cem_core_state_t state;
	cem_core_state_t next_state;

	logic [CEM_NUM_EVENTS-1:0] event_vec;
	logic [CEM_NUM_EVENTS-1:0] mask_vec;
	logic [CEM_NUM_EVENTS-1:0] pass_vec;

	// level events become edge events; regulation ones fire on both edges
	always_comb begin
		event_vec = '0;
		event_vec[CEM_BIT_LINE_DETECT] = line_detect_done_i;
		event_vec[CEM_BIT_CONV_DONE]   = conv_done_i & conv_single_shot_i;
		event_vec[CEM_BIT_MIN_SYS]     = min_sys_reg_i ^ state.min_sys_q;
		event_vec[CEM_BIT_FAST_TMR]    = fast_timer_expire_i;
		event_vec[CEM_BIT_TRICKLE_TMR] = trickle_timer_expire_i;
		event_vec[CEM_BIT_PRE_TMR]     = pre_timer_expire_i;
		event_vec[CEM_BIT_TOPOFF_TMR]  = topoff_timer_expire_i;
		event_vec[CEM_EV_TEMP_LSB +: 4] = thermistor_cross_i;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_BAT_CUR_REG] = bat_cur_reg_i ^ state.bat_cur_q;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_BUS_OVP]   = bus_ovp_i & ~state.bus_ovp_q;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_BAT_OVP]   = bat_ovp_i & ~state.bat_ovp_q;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_IN_OCP]    = in_ocp_i;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_BAT_OCP]   = bat_ocp_i;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_CONV_OCP]  = conv_ocp_i;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_ADP_B_OVP] = adp_b_ovp_i & ~state.adp_b_q;
		event_vec[CEM_EV_FAULT_LSB + CEM_BIT_ADP_A_OVP] = adp_a_ovp_i & ~state.adp_a_q;
	end

	assign mask_vec = {mif.fault_mask, mif.temp_mask[3:0], mif.timer_mask[6:0]};

	// masking stops both the pulse and the cause bit; event flags live elsewhere and are untouched
	genvar g;
	generate
		for (g = 0; g < CEM_NUM_EVENTS; g++) begin : g_gate
			assign pass_vec[g] = event_vec[g] & ~mask_vec[g];
		end
	endgenerate

	always_comb begin
		next_state           = state;
		next_state.min_sys_q = min_sys_reg_i;
		next_state.bat_cur_q = bat_cur_reg_i;
		next_state.bus_ovp_q = bus_ovp_i;
		next_state.bat_ovp_q = bat_ovp_i;
		next_state.adp_b_q   = adp_b_ovp_i;
		next_state.adp_a_q   = adp_a_ovp_i;
		// one-cycle pulse per cycle holding any unmasked event
		next_state.irq       = |pass_vec;
		next_state.cause     = pass_vec;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign irq_pulse_o = state.irq;
	assign irq_cause_o = state.cause;

endmodule

//--- verification/cem_irq_mask_props.sv
module cem_irq_mask_props
	import cem_pkg::*;
(
	input wire logic        clk_i, reset_i, reg_wr_i, reg_rst_cmd_i, watchdog_expire_i,
	input wire logic [7:0]  reg_addr_i, reg_wdata_i,
	input wire logic        line_detect_done_i, conv_done_i, conv_single_shot_i, min_sys_reg_i,
	input wire logic        fast_timer_expire_i, bat_cur_reg_i, bus_ovp_i, irq_pulse_o,
	input wire logic [3:0]  thermistor_cross_i,
	input wire logic [18:0] irq_cause_o
);
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [7:0] tm, pm, fm;
	} cem_shadow_t;
	cem_shadow_t s, next_s;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// shadow of the masks; an event sees the value held before its edge
	always_comb begin
		next_s = s;
		if (reg_wr_i && reg_addr_i == CEM_OFF_TIMER_MASK) next_s.tm = reg_wdata_i;
		if (reg_wr_i && reg_addr_i == CEM_OFF_TEMP_MASK) next_s.pm = reg_wdata_i;
		if (reg_wr_i && reg_addr_i == CEM_OFF_FAULT_MASK) next_s.fm = reg_wdata_i;
		if (watchdog_expire_i) next_s.pm = next_s.pm & ~CEM_TEMP_WD_BITS;
		if (reg_rst_cmd_i) next_s = '0;
	end
	always_ff @(posedge clk_i) s <= reset_i ? '0 : next_s;
	pulse_cause_a: assert property (irq_pulse_o == |irq_cause_o)
		else $error("pulse and cause disagree");
	line_detect_a: assert property (line_detect_done_i |=> irq_cause_o[6] == !$past(s.tm[6]))
		else $error("line detect gating wrong");
	conv_done_a: assert property (conv_done_i |=> irq_cause_o[5] ==
		$past(conv_single_shot_i && !s.tm[5])) else $error("conversion gating wrong");
	min_sys_a: assert property ($changed(min_sys_reg_i) |=> irq_cause_o[4] == !$past(s.tm[4]))
		else $error("min system gating wrong");
	fast_timer_a: assert property (fast_timer_expire_i |-> ##1 irq_cause_o[3] != $past(s.tm[3]))
		else $error("fast timer gating wrong");
	thermal_gate_a: assert property (1'b1 |=> irq_cause_o[10:7] ==
		$past(thermistor_cross_i & ~s.pm[3:0])) else $error("zone gating wrong");
	zone_clear_a: assert property (watchdog_expire_i ##1 thermistor_cross_i[0] |=> irq_cause_o[7])
		else $error("watchdog left zone mask set");
	cur_reg_a: assert property ($changed(bat_cur_reg_i) |=> irq_cause_o[18] == !$past(s.fm[7]))
		else $error("current regulation gating wrong");
	unmasked_pulse_a: assert property (fast_timer_expire_i && !s.tm[3] |=> irq_pulse_o)
		else $error("unmasked event gave no pulse");
	bus_ovp_a: assert property ($rose(bus_ovp_i) |=> irq_cause_o[17] == !$past(s.fm[6]))
		else $error("bus overvoltage gating wrong");
	ovp_level_a: assert property (bus_ovp_i && $past(bus_ovp_i) |=> !irq_cause_o[17])
		else $error("overvoltage level pulsed again");
	cover property (fast_timer_expire_i && s.tm[3]);
	cover property (watchdog_expire_i ##1 thermistor_cross_i[0]);
	cover property (irq_pulse_o && !$onehot(irq_cause_o));
endmodule
bind cem_irq_mask cem_irq_mask_props cem_irq_mask_props_inst (.*);

//--- verification/cem_host_model.sv
module cem_host_model (
	input  wire logic clk_i,
	input  wire logic irq_i,
	output int        count_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int taken = 0;
	// the host sees only the line, so each high cycle is one interrupt taken
	always @(posedge clk_i) if (irq_i === 1'b1) taken <= taken + 1;
	assign count_o = taken;
endmodule

//--- verification/testbench.sv
module testbench
	import cem_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i, reset_i, reg_wr_i, reg_rst_cmd_i, watchdog_expire_i, irq_pulse_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [18:0] irq_cause_o;
	logic [19:0] ev;
	logic [31:0] r;
	logic [18:0] x;
	logic [7:0]  rx;
	logic [7:0]  m [4];
	logic [19:0] pv;
	int          h0, pulses;
	int          err_total = 0, comparisons = 0, host_cnt;
	logic [7:0]  wm [4] = '{CEM_WMASK_TIMER, CEM_WMASK_TEMP, CEM_WMASK_FAULT, 8'h00};
	cem_irq_mask cem_irq_mask_inst (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .reg_rst_cmd_i, .watchdog_expire_i, .line_detect_done_i(ev[6]),
		.conv_done_i(ev[5]), .conv_single_shot_i(ev[7]), .min_sys_reg_i(ev[4]),
		.fast_timer_expire_i(ev[3]), .trickle_timer_expire_i(ev[2]), .pre_timer_expire_i(ev[1]),
		.topoff_timer_expire_i(ev[0]), .thermistor_cross_i(ev[11:8]), .bat_cur_reg_i(ev[19]),
		.bus_ovp_i(ev[18]), .bat_ovp_i(ev[17]), .in_ocp_i(ev[16]), .bat_ocp_i(ev[15]),
		.conv_ocp_i(ev[14]), .adp_b_ovp_i(ev[13]), .adp_a_ovp_i(ev[12]), .irq_pulse_o,
		.irq_cause_o);
	cem_host_model cem_host_model_inst (.clk_i, .irq_i(irq_pulse_o), .count_o(host_cnt));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// cause bits expected when every event fires at once
	function automatic logic [18:0] passed(input logic [7:0] t, p, f);
		return ~{f, p[3:0], t[6:0]};
	endfunction
	// cause for one edge: pulses pass, levels fire on their edges, then the masks apply
	function automatic logic [18:0] expect_cause(input logic [19:0] e, p, input logic [7:0] t, z, f);
		return {e[19] ^ p[19], e[18:17] & ~p[18:17], e[16:14], e[13:12] & ~p[13:12], e[11:8],
			e[6], e[5] & e[7], e[4] ^ p[4], e[3:0]} & ~{f, z[3:0], t[6:0]};
	endfunction
	task automatic check(input bit ok);
		comparisons++;
		if (!ok) begin
			err_total++;
			$display("ERROR %0t readback or cause mismatch", $time);
		end
	endtask
	task automatic drive(input logic w, c, d, input logic [7:0] a, x);
		@(posedge clk_i);
		#1;
		{reg_wr_i, reg_rst_cmd_i, watchdog_expire_i, reg_addr_i, reg_wdata_i} = {w, c, d, a, x};
	endtask
	task automatic rd_chk(input logic [7:0] a, x);
		drive(0, 0, 0, a, 8'h00);
		drive(0, 0, 0, a, 8'h00);
		check(reg_rdata_o === x);
	endtask
	task automatic ev_chk(input logic [19:0] e, input logic [18:0] x);
		drive(0, 0, 0, 8'h00, 8'h00);
		ev = e;
		drive(0, 0, 0, 8'h00, 8'h00);
		ev = '0;
		check(irq_cause_o === x && irq_pulse_o === |x);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d pulses %0d", comparisons, err_total, host_cnt);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#40000;
		err_total++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
	initial begin
		reset_i = 1'b1;
		{reg_wr_i, reg_rst_cmd_i, watchdog_expire_i, reg_addr_i, reg_wdata_i, ev} = '0;
		r = $urandom(32'h3160);
		repeat (2) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd_chk(8'h2A + 8'(i), 8'h00);
			drive(1, 0, 0, 8'h2A + 8'(i), 8'hFF);
			rd_chk(8'h2A + 8'(i), wm[i]);
		end
		ev_chk(20'hFFFFF, passed(wm[0], wm[1], wm[2]));
		drive(0, 0, 1, 8'h00, 8'h00);
		rd_chk(CEM_OFF_TEMP_MASK, wm[1] & ~CEM_TEMP_WD_BITS);
		rd_chk(CEM_OFF_FAULT_MASK, wm[2]);
		ev_chk(20'hFFFFF, passed(wm[0], wm[1] & ~CEM_TEMP_WD_BITS, wm[2]));
		drive(0, 1, 0, 8'h00, 8'h00);
		rd_chk(CEM_OFF_TIMER_MASK, 8'h00);
		ev_chk(20'hFFFFF, passed(8'h00, 8'h00, 8'h00));
		m = '{4{8'h00}};
		pv = '0;
		pulses = 0;
		for (int k = 0; k <= 2000; k++) begin
			r = $urandom;
			// strobes drawn apart so that clashes of write, watchdog and reset occur
			drive(r[1:0] == 2'h0, r[6:2] == 5'h00, r[11:7] < 5'h03, 8'h2A + 8'(r[13:12]), r[23:16]);
			if (k > 0) begin
				check(irq_cause_o === x && irq_pulse_o === |x && reg_rdata_o === rx);
				pulses += int'(|x);
			end
			if (k == 1) h0 = host_cnt;
			ev = 20'($urandom);
			x = expect_cause(ev, pv, m[0], m[1], m[2]);
			rx = m[r[13:12]];
			pv = ev;
			if (r[1:0] == 2'h0) m[r[13:12]] = r[23:16] & wm[r[13:12]];
			if (r[11:7] < 5'h03) m[1] = m[1] & ~CEM_TEMP_WD_BITS;
			if (r[6:2] == 5'h00) m = '{4{8'h00}};
		end
		drive(0, 0, 0, 8'h00, 8'h00);
		check(host_cnt - h0 == pulses);
		give_verdict();
	end
endmodule
